// ==== design/vcar_pkg.sv ====
// ****************************************************************
// Shared constants for the violation counter access registers.
// ****************************************************************
package vcar_pkg;

   // ****************************************************************
   // Sizes.
   // ****************************************************************
   localparam int CHAN_NUM = 8; // Number of line channels.
   localparam int CNT_W = 16; // Width of each violation counter.
   localparam int REG_W = 8; // Width of every host register.
   localparam int ADDR_W = 8; // Width of the host register address.
   localparam int IDX_W = 3; // Width of a channel index.
   localparam int SEL_W = 4; // Width of the channel selector field.

   // ****************************************************************
   // Register offsets on the host port.
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_SLICER = 8'h83; // Slicer threshold configuration.
   localparam logic [ADDR_W-1:0] ADDR_CHAN_SEL = 8'h8C; // Counter channel select.
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h8D; // Counter clear and snapshot control.
   localparam logic [ADDR_W-1:0] ADDR_READBACK = 8'h8E; // Counter byte readback, read only here.

   // ****************************************************************
   // Reset values.
   // ****************************************************************
   localparam logic [REG_W-1:0] SLICER_RST = 8'h00; // Slicer field resets to the 60 percent code.
   localparam logic [REG_W-1:0] CHAN_SEL_RST = 8'h00; // Selector resets to the no-channel code.
   localparam logic [REG_W-1:0] CTRL_RST = 8'h00; // All controls idle after reset.
   localparam logic [REG_W-1:0] RDATA_ZERO = 8'h00; // Answer for unmapped or unselected reads.
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000; // Cleared counter value.
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001; // Counter increment.

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int SL_LSB = 2; // Slicer threshold select, low bit.
   localparam int SL_MSB = 3; // Slicer threshold select, high bit.
   localparam int CHSEL_MSB = 3; // Channel selector occupies bits 3..0.
   localparam int CTRL_CH_CLR = 0; // Per-channel counter clear.
   localparam int CTRL_CH_SNAP = 1; // Per-channel counter snapshot.
   localparam int CTRL_BYTE_PICK = 2; // Readback byte pick, 1 = high byte.
   localparam int CTRL_ALL_SNAP = 3; // Snapshot of all channels.
   localparam int CTRL_ALL_CLR = 4; // Clear of all channels.

   // ****************************************************************
   // Channel selector codes.
   // ****************************************************************
   localparam logic [SEL_W-1:0] CHAN_CODE_NONE = 4'h0; // No channel selected.
   localparam logic [SEL_W-1:0] CHAN_CODE_FIRST = 4'h1; // Code of channel 0.
   localparam logic [SEL_W-1:0] CHAN_CODE_LAST = 4'h8; // Code of channel 7.

   // ****************************************************************
   // Timing.
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 25; // System clock period at 40 MHz.
   localparam int CLR_HOLD_NS = 1000; // Least time the host holds a clear bit.
   localparam int CLR_HOLD_CYC = (CLR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Rounded up.

endpackage

// ==== design/vcar_chan_counter.sv ====
`timescale 1ns/10ps
// ****************************************************************
// One channel: live violation counter and its holding register.
// ****************************************************************
module vcar_chan_counter import vcar_pkg::*; (
   // Clock and synchronised reset.
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Violation event from the line, controls from the register bank.
   input wire logic line_code_violation_i,
   input wire logic clear_i,
   input wire logic snap_i,
   // Held value for readback.
   output logic [CNT_W-1:0] held_o
);

   logic [CNT_W-1:0] cnt_q; // Live count.
   logic [CNT_W-1:0] cnt_d; // Next live count.
   logic [CNT_W-1:0] held_q; // Frozen copy for the host.
   logic [CNT_W-1:0] held_d; // Next frozen copy.

   // Clear is a level and beats a violation in the same cycle; the count wraps at full scale.
   assign cnt_d = clear_i ? CNT_ZERO :
                  line_code_violation_i ? cnt_q + CNT_ONE : cnt_q;
   // The holding register only moves while a snapshot is requested.
   assign held_d = snap_i ? cnt_q : held_q;
   assign held_o = held_q;

   // Counter and holding register.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= CNT_ZERO;
         held_q <= CNT_ZERO;
      end else begin
         cnt_q <= cnt_d;
         held_q <= held_d;
      end
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   a_clear_zeroes: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      clear_i |=> cnt_q == CNT_ZERO) else $error("Counter not zero after clear.");
   a_count_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !clear_i && line_code_violation_i |=> cnt_q == $past(cnt_q) + CNT_ONE)
      else $error("Counter did not step on a violation.");
   a_snap_copy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      snap_i |=> held_q == $past(cnt_q)) else $error("Snapshot did not copy live count.");
   a_held_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !snap_i |=> $stable(held_q)) else $error("Holding register moved without snapshot.");

endmodule

// ==== design/vcar_regs.sv ====
`timescale 1ns/10ps
module vcar_regs import vcar_pkg::*; (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Host register port.
   input wire logic [ADDR_W-1:0] host_addr_i,
   input wire logic [REG_W-1:0] host_wdata_i,
   input wire logic host_wr_i,
   input wire logic host_rd_i,
   // Violation events from the receive decoders.
   input wire logic [CHAN_NUM-1:0] line_code_violation_i,
   // Slicer level to the receive front end.
   output logic [1:0] slicer_threshold_sel_o,
   // Read answer.
   output logic [REG_W-1:0] host_rdata_o,
   output logic host_rvalid_o
);

   // ****************************************************************
   // Reset release.
   // ****************************************************************
   logic rst_meta_q; // First stage, read only by the second.
   logic rst_n_q; // Second stage, the released reset itself.
   logic rst_n; // Synchronised reset used by all other logic.
   assign rst_n = rst_n_q;

   // Release the reset through two flops so every flop behind them leaves reset on the same edge.
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ****************************************************************
   // Register storage.
   // ****************************************************************
   logic [REG_W-1:0] slicer_cfg_q; // Whole slicer byte, unused bits kept as storage.
   logic [REG_W-1:0] chan_sel_q; // Channel selector byte, upper bits are storage.
   logic [REG_W-1:0] ctrl_q; // Clear, snapshot and byte pick controls.
   logic [REG_W-1:0] rdata_q; // Registered read answer.
   logic rvalid_q; // Read answer strobe.

   // Write strobes for each writable register.
   logic wr_slicer;
   logic wr_chan_sel;
   logic wr_ctrl;
   assign wr_slicer = host_wr_i && (host_addr_i == ADDR_SLICER);
   assign wr_chan_sel = host_wr_i && (host_addr_i == ADDR_CHAN_SEL);
   assign wr_ctrl = host_wr_i && (host_addr_i == ADDR_CTRL);

   // Control fields decoded from the stored bytes.
   logic [SEL_W-1:0] violation_counter_chan_sel; // Selector code.
   logic all_counters_clear; // Level clear of all counters.
   logic all_counters_snapshot; // Level snapshot of all counters.
   logic chan_counter_clear; // Level clear of the selected counter.
   logic chan_counter_snapshot; // Level snapshot of the selected counter.
   logic counter_byte_pick; // 1 picks the high byte.
   assign violation_counter_chan_sel = chan_sel_q[CHSEL_MSB:0];
   assign all_counters_clear = ctrl_q[CTRL_ALL_CLR];
   assign all_counters_snapshot = ctrl_q[CTRL_ALL_SNAP];
   assign chan_counter_clear = ctrl_q[CTRL_CH_CLR];
   assign chan_counter_snapshot = ctrl_q[CTRL_CH_SNAP];
   assign counter_byte_pick = ctrl_q[CTRL_BYTE_PICK];

   // Writes store whole bytes; reserved bits are kept and read back.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         slicer_cfg_q <= SLICER_RST;
         chan_sel_q <= CHAN_SEL_RST;
         ctrl_q <= CTRL_RST;
      end else begin
         if (wr_slicer) begin
            slicer_cfg_q <= host_wdata_i;
         end
         if (wr_chan_sel) begin
            chan_sel_q <= host_wdata_i;
         end
         if (wr_ctrl) begin
            ctrl_q <= host_wdata_i;
         end
      end
   end

   // The slicer level is a field of a flop, so the output is glitch free.
   assign slicer_threshold_sel_o = slicer_cfg_q[SL_MSB:SL_LSB];

   // ****************************************************************
   // Channel decode.
   // ****************************************************************
   logic chan_valid; // Selector holds a channel code.
   logic [SEL_W-1:0] chan_off; // Code less one.
   logic [IDX_W-1:0] chan_idx; // Channel number 0..7.
   assign chan_valid = (violation_counter_chan_sel >= CHAN_CODE_FIRST) &&
                       (violation_counter_chan_sel <= CHAN_CODE_LAST);
   assign chan_off = violation_counter_chan_sel - CHAN_CODE_FIRST;
   assign chan_idx = chan_off[IDX_W-1:0];

   logic [CHAN_NUM-1:0] chan_hit; // One-hot selected channel, zero if invalid.
   logic [CHAN_NUM-1:0] clear_vec; // Per-channel clear level.
   logic [CHAN_NUM-1:0] snap_vec; // Per-channel snapshot level.
   logic [CNT_W-1:0] held_w [CHAN_NUM]; // Held counts of all channels.

   // One counter per channel; global and per-channel controls merge here.
   for (genvar g = 0; g < CHAN_NUM; g++) begin : g_chan
      assign chan_hit[g] = chan_valid && (chan_idx == IDX_W'(g));
      assign clear_vec[g] = all_counters_clear || (chan_counter_clear && chan_hit[g]);
      assign snap_vec[g] = all_counters_snapshot || (chan_counter_snapshot && chan_hit[g]);
      vcar_chan_counter u_cnt (
         .clk_sys_i(clk_sys_i),
         .rst_n_i(rst_n),
         .line_code_violation_i(line_code_violation_i[g]),
         .clear_i(clear_vec[g]),
         .snap_i(snap_vec[g]),
         .held_o(held_w[g])
      );
   end

   // ****************************************************************
   // Read path.
   // ****************************************************************
   logic [CNT_W-1:0] held_sel; // Held count of the selected channel.
   logic [REG_W-1:0] readback_byte; // Byte shown at the readback offset.
   logic [REG_W-1:0] rd_mux; // Answer for the current address.
   assign held_sel = held_w[chan_idx];
   assign readback_byte = !chan_valid ? RDATA_ZERO :
                          counter_byte_pick ? held_sel[CNT_W-1:REG_W] : held_sel[REG_W-1:0];
   assign rd_mux = (host_addr_i == ADDR_SLICER) ? slicer_cfg_q :
                   (host_addr_i == ADDR_CHAN_SEL) ? chan_sel_q :
                   (host_addr_i == ADDR_CTRL) ? ctrl_q :
                   (host_addr_i == ADDR_READBACK) ? readback_byte : RDATA_ZERO;

   // The answer is sampled at the read strobe and stands until the next read.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= RDATA_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= host_rd_i;
         if (host_rd_i) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign host_rdata_o = rdata_q;
   assign host_rvalid_o = rvalid_q;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   logic [5:0] clr_run_q; // Cycles the global clear has been held, saturating.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         clr_run_q <= 6'h00;
      end else if (!all_counters_clear) begin
         clr_run_q <= 6'h00;
      end else if (clr_run_q != 6'h3F) begin
         clr_run_q <= clr_run_q + 6'h01;
      end
   end

   a_slicer_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      wr_slicer |=> slicer_threshold_sel_o == $past(host_wdata_i[SL_MSB:SL_LSB]))
      else $error("Slicer field not updated by write.");
   // Every bit of the slicer byte is stored, the spare ones included, and reads return the whole byte.
   a_slicer_spare: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      wr_slicer |=> slicer_cfg_q == $past(host_wdata_i)) else $error("Slicer spare bits not stored.");
   a_slicer_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      host_rd_i && host_addr_i == ADDR_SLICER |=> host_rdata_o == $past(slicer_cfg_q))
      else $error("Slicer byte not read back.");
   a_bad_code_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !chan_valid && !all_counters_clear && !all_counters_snapshot |-> clear_vec == '0 && snap_vec == '0)
      else $error("Invalid selector still acts on a channel.");
   a_chan_target: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      chan_valid && chan_counter_clear && !all_counters_clear |-> clear_vec == (CHAN_NUM'(1) << chan_idx))
      else $error("Channel clear hit the wrong channel.");
   a_all_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      all_counters_clear |-> &clear_vec) else $error("Global clear missed a channel.");
   a_all_snap: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      all_counters_snapshot |-> &snap_vec) else $error("Global snapshot missed a channel.");
   a_readback_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      host_rd_i && host_addr_i == ADDR_READBACK && !chan_valid |=> host_rdata_o == RDATA_ZERO)
      else $error("Unselected readback not zero.");
   a_readback_byte: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      host_rd_i && host_addr_i == ADDR_READBACK && chan_valid |=> host_rvalid_o &&
      host_rdata_o == ($past(counter_byte_pick) ? $past(held_sel[CNT_W-1:REG_W]) : $past(held_sel[REG_W-1:0])))
      else $error("Readback byte wrong.");
   // A channel snapshot must not leak into the other holding registers.
   a_chan_snap_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      chan_valid && chan_counter_snapshot && !all_counters_snapshot |-> snap_vec == (CHAN_NUM'(1) << chan_idx))
      else $error("Channel snapshot hit the wrong channel.");
   // The control byte, byte pick included, is stored as written.
   a_ctrl_store: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      wr_ctrl |=> ctrl_q == $past(host_wdata_i)) else $error("Control byte not stored.");
   // Read strobe and answer timing: one valid cycle per read, data standing in between.
   a_rvalid_after: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      host_rd_i |=> host_rvalid_o) else $error("Read answer strobe missing.");
   a_rvalid_single: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !host_rd_i |=> !host_rvalid_o) else $error("Read answer strobe without a read.");
   a_rdata_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !host_rd_i |=> $stable(host_rdata_o)) else $error("Read data moved without a read.");

   c_long_clear: cover property (@(posedge clk_sys_i) disable iff (!rst_n) clr_run_q >= 6'(CLR_HOLD_CYC));
   c_chan_snap: cover property (@(posedge clk_sys_i) disable iff (!rst_n) chan_valid && chan_counter_snapshot);
   c_high_byte: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
      host_rd_i && host_addr_i == ADDR_READBACK && chan_valid && counter_byte_pick);
   c_bad_sel_read: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
      host_rd_i && host_addr_i == ADDR_READBACK && !chan_valid);

endmodule

// ==== tb/vcar_viol_src.sv ====
`timescale 1ns/10ps
// *****
// Line-side model: the receive decoders raising violation events.
// *****
module vcar_viol_src import vcar_pkg::*; (
   // Clock.
   input wire logic clk_sys_i,
   // Events towards the counters.
   output logic [CHAN_NUM-1:0] viol_o
);
   // Lines rest low so that no event is counted by accident.
   initial begin
      viol_o = '0;
   end

   // Raises the masked lines for n cycles; every high cycle is one event.
   task automatic pulse(input logic [CHAN_NUM-1:0] mask, input int n);
      @(negedge clk_sys_i);
      viol_o = mask;
      repeat (n) @(negedge clk_sys_i);
      viol_o = '0;
   endtask
endmodule

// ==== tb/vcar_regs_tb.sv ====
`timescale 1ns/10ps
// *****
// Bench for the violation counter access registers.
// *****
module vcar_regs_tb import vcar_pkg::*;;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [REG_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [CHAN_NUM-1:0] viol;
   logic [1:0] slicer;
   logic [REG_W-1:0] rdata;
   logic rvalid;
   // Expected live and held counts, kept by the bench itself.
   logic [CNT_W-1:0] live [CHAN_NUM];
   logic [CNT_W-1:0] held [CHAN_NUM];
   int err_count = 0;
   int n_tests = 0;

   always #12.5 clk_sys_i = ~clk_sys_i;

   vcar_regs dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .host_addr_i(addr), .host_wdata_i(wdata),
      .host_wr_i(wr), .host_rd_i(rd), .line_code_violation_i(viol), .slicer_threshold_sel_o(slicer),
      .host_rdata_o(rdata), .host_rvalid_o(rvalid));
   vcar_viol_src src (.clk_sys_i(clk_sys_i), .viol_o(viol));

   // *****
   // Access tasks.
   // *****
   task automatic chk(input string what, input logic [REG_W-1:0] exp, input logic [REG_W-1:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One write strobe; it is taken at the single rising edge it spans.
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      @(negedge clk_sys_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_sys_i);
      wr = 1'b0;
   endtask

   // The answer stands from the read edge on, so it is looked at on the falling edge half a cycle later.
   task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
      @(negedge clk_sys_i);
      addr = a;
      rd = 1'b1;
      @(negedge clk_sys_i);
      rd = 1'b0;
      chk({what, " valid"}, 8'h01, {7'h00, rvalid});
      chk(what, exp, rdata);
   endtask

   task automatic hit(input logic [CHAN_NUM-1:0] mask, input int n);
      src.pulse(mask, n);
      for (int c = 0; c < CHAN_NUM; c++) begin
         if (mask[c]) begin
            live[c] = live[c] + CNT_W'(n);
         end
      end
   endtask

   task automatic snap_all();
      wr_reg(ADDR_CTRL, 8'h08);
      wr_reg(ADDR_CTRL, 8'h00);
      held = live;
   endtask

   // Only a valid code moves a holding register.
   task automatic snap_one(input logic [SEL_W-1:0] code);
      wr_reg(ADDR_CHAN_SEL, {4'h0, code});
      wr_reg(ADDR_CTRL, 8'h02);
      wr_reg(ADDR_CTRL, 8'h00);
      if (code >= CHAN_CODE_FIRST && code <= CHAN_CODE_LAST) begin
         held[code - 1] = live[code - 1];
      end
   endtask

   // The host keeps a clear bit up for at least a microsecond while events go on.
   task automatic hold_clr(input logic [REG_W-1:0] v, input logic [CHAN_NUM-1:0] gone);
      wr_reg(ADDR_CTRL, v);
      hit(8'hFF, CLR_HOLD_CYC);
      wr_reg(ADDR_CTRL, 8'h00);
      for (int c = 0; c < CHAN_NUM; c++) begin
         if (gone[c]) begin
            live[c] = CNT_ZERO;
         end
      end
   endtask

   // Reads both bytes of every channel through the selector.
   task automatic check_all();
      for (int c = 0; c < CHAN_NUM; c++) begin
         wr_reg(ADDR_CHAN_SEL, REG_W'(c + 1));
         rd_chk("low byte", ADDR_READBACK, held[c][7:0]);
         wr_reg(ADDR_CTRL, 8'h04);
         rd_chk("high byte", ADDR_READBACK, held[c][15:8]);
         wr_reg(ADDR_CTRL, 8'h00);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Watchdog sized well above the roughly 1100 cycles the tests need.
   initial begin
      #(CLK_PERIOD_NS * 30000);
      err_count++;
      wrap_up();
   end

   // *****
   // Test sequence.
   // *****
   initial begin
      // The model starts from the counts that reset gives.
      for (int c = 0; c < CHAN_NUM; c++) begin
         live[c] = CNT_ZERO;
         held[c] = CNT_ZERO;
      end
      repeat (5) @(negedge clk_sys_i);
      // Outputs must already sit at their idle values while reset is held.
      chk("reset slicer", 8'h00, {6'h00, slicer});
      chk("reset rdata", RDATA_ZERO, rdata);
      chk("reset valid", 8'h00, {7'h00, rvalid});
      arst_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      rd_chk("slicer reg", ADDR_SLICER, SLICER_RST);
      rd_chk("chan sel", ADDR_CHAN_SEL, CHAN_SEL_RST);
      rd_chk("ctrl", ADDR_CTRL, CTRL_RST);
      rd_chk("readback", ADDR_READBACK, RDATA_ZERO);
      rd_chk("unmapped", 8'h84, RDATA_ZERO);
      $display("test reset done");
      // Every slicer code, with the spare bits carrying a pattern.
      for (int k = 0; k < 4; k++) begin
         wr_reg(ADDR_SLICER, {4'hA, 2'(k), 2'h1});
         rd_chk("slicer reg", ADDR_SLICER, {4'hA, 2'(k), 2'h1});
         chk("slicer out", {6'h00, 2'(k)}, {6'h00, slicer});
      end
      $display("test slicer done");
      // Distinct counts per channel; channel 7 crosses into the high byte.
      for (int c = 0; c < CHAN_NUM; c++) begin
         hit(CHAN_NUM'(1) << c, c + 1);
      end
      hit(8'h80, 256);
      snap_all();
      wr_reg(ADDR_READBACK, 8'hFF);
      check_all();
      $display("test global snapshot done");
      hit(8'h03, 2);
      check_all();
      snap_one(4'h1);
      check_all();
      $display("test channel snapshot done");
      wr_reg(ADDR_CHAN_SEL, 8'h02);
      hold_clr(8'h01, 8'h02);
      snap_all();
      check_all();
      $display("test channel clear done");
      // Out-of-range selector: no clear, no snapshot, zero readback.
      wr_reg(ADDR_CHAN_SEL, 8'h09);
      hold_clr(8'h01, 8'h00);
      snap_one(4'h9);
      rd_chk("readback bad sel", ADDR_READBACK, RDATA_ZERO);
      wr_reg(ADDR_CHAN_SEL, 8'h00);
      rd_chk("readback no sel", ADDR_READBACK, RDATA_ZERO);
      check_all();
      snap_all();
      check_all();
      $display("test invalid selector done");
      hold_clr(8'h10, 8'hFF);
      snap_all();
      check_all();
      $display("test global clear done");
      wrap_up();
   end
endmodule
